//--- sro_status_bank.sv
// Status register one stored bank with write lock and block protection
// Overview of operation
// R01 - Lock set and pin low ignore writes
// R02 - Pin high always allows these writes
// R03 - Lock clear makes the pin irrelevant
// R04 - Pin never blocks other register writes
// R05 - Live bit 7 mirrors stored lock
// R06 - Stored program-error default seeds live bit 6
// R07 - Stored erase-error default seeds live bit 5
// R08 - Stored latch default seeds live bit 1
// R09 - Stored busy default seeds live bit 0
// R10 - Select clear: field stored and copied live
// R11 - Select set: only live field written
// R12 - Protected region refuses program and erase
// R13 - Whole erase needs all protection clear
// R14 - Volatile select pins stored field at 111b
// R15 - Reset loads live copies from stored
`timescale 1ns/1ps
module sro_status_bank
  import sro_pkg::*;
(
  input  wire logic     i_sys_clk,
  input  wire logic     i_resetn,
  input  wire logic     i_write_protect_n,
  input  wire logic [7:0] i_nv_status_image,
  input  wire logic [7:0] i_nv_config_image,
  input  wire sro_cmd_t i_cmd,
  input  wire sro_evt_t i_evt,
  output sro_rsp_t      o_rsp,
  output sro_nv_t       o_nv,
  output logic [7:0]    o_status_live,
  output logic [7:0]    o_status_stored,
  output logic [7:0]    o_config_live,
  output logic [2:0]    o_protect_active
);

  logic       wp_high;          // Filtered write-protect pin level
  logic [7:0] status_stored;    // Non-volatile status one copy
  logic [7:0] status_live;      // Volatile status one
  logic [7:0] config_stored;    // Non-volatile config one copy
  logic [7:0] config_live;      // Volatile config one
  logic [7:0] next_status_stored;
  logic [7:0] next_status_live;
  logic [7:0] next_config_stored;
  logic [7:0] next_config_live;
  sro_rsp_t   next_rsp;
  sro_nv_t    next_nv;
  logic       vsel;             // Protection taken from live field
  logic [2:0] active_field;     // Field that protects the array
  logic       locked;           // Status and config one are frozen
  logic       hits_guarded;     // Command writes status or config one

  // Pin crosses into the clock domain before anyone looks at it
  sro_pin_sync u_wp_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_write_protect_n),
    .o_level   (wp_high)
  );

  // Active protection source and lock decode
  always_comb
  begin
    vsel         = config_stored[VSEL_BIT];
    active_field = vsel ? status_live[FIELD_HI:FIELD_LO]            // R11
                        : status_stored[FIELD_HI:FIELD_LO];         // R10
    locked       = status_stored[LOCK_BIT] & ~wp_high;      // R01 R02 R03
    // Only write commands aimed at status or config one can be frozen
    hits_guarded = 1'b0;
    if (i_cmd.kind == CMD_WRITE_REGISTERS)
    begin
      hits_guarded = 1'b1;
    end
    else if (i_cmd.kind == CMD_WRITE_ANY)
    begin
      hits_guarded = (i_cmd.sel != SEL_OTHER);                      // R04
    end
  end

  // Next values of all registers and the answer
  always_comb
  begin
    next_status_stored = status_stored;
    next_status_live   = status_live;
    next_config_stored = config_stored;
    next_config_live   = config_live;
    next_rsp           = '0;
    next_nv            = '0;

    // Engine events; a set beats a clear in the same cycle
    next_status_live[PERR_BIT] = i_evt.perr_set
                               | (status_live[PERR_BIT] & ~i_evt.err_clr);
    next_status_live[EERR_BIT] = i_evt.eerr_set
                               | (status_live[EERR_BIT] & ~i_evt.err_clr);
    next_status_live[WEL_BIT]  = i_evt.wel_set
                               | (status_live[WEL_BIT] & ~i_evt.wel_clr);
    next_status_live[BUSY_BIT] = i_evt.busy;

    if (i_cmd.valid)
    begin
      next_rsp.valid = 1'b1;
      if (hits_guarded && locked)
      begin
        // Frozen: the command is dropped untouched
        next_rsp.refused = 1'b1;                                    // R01
      end
      else
      begin
        case (i_cmd.kind)
          CMD_WRITE_REGISTERS:
          begin
            next_rsp.done = 1'b1;                               // R02 R03
            next_status_stored[LOCK_BIT] = i_cmd.data[LOCK_BIT];
            if (!vsel)
            begin
              // Program stored field and copy it live
              next_status_stored[FIELD_HI:FIELD_LO] =
                i_cmd.data[FIELD_HI:FIELD_LO];                      // R10
              next_status_live[FIELD_HI:FIELD_LO] =
                i_cmd.data[FIELD_HI:FIELD_LO];                      // R10
            end
            else
            begin
              // Stored field untouched in volatile mode
              next_status_live[FIELD_HI:FIELD_LO] =
                i_cmd.data[FIELD_HI:FIELD_LO];                      // R11
            end
            if (i_cmd.cfg_valid)
            begin
              next_config_stored = i_cmd.cfg_data;
              // Volatility select is one-time: once set it stays set
              next_config_stored[VSEL_BIT] = config_stored[VSEL_BIT]
                                           | i_cmd.cfg_data[VSEL_BIT];
              next_config_live = next_config_stored;
            end
          end
          CMD_WRITE_ANY:
          begin
            next_rsp.done = 1'b1;
            case (i_cmd.sel)
              SEL_STATUS_STORED:
              begin
                next_status_stored[LOCK_BIT] = i_cmd.data[LOCK_BIT];
                if (!vsel)
                begin
                  next_status_stored[FIELD_HI:FIELD_LO] =
                    i_cmd.data[FIELD_HI:FIELD_LO];                  // R10
                  next_status_live[FIELD_HI:FIELD_LO] =
                    i_cmd.data[FIELD_HI:FIELD_LO];                  // R10
                end
              end
              SEL_STATUS_LIVE:
              begin
                // Live field is user writable only in volatile mode
                if (vsel)
                begin
                  next_status_live[FIELD_HI:FIELD_LO] =
                    i_cmd.data[FIELD_HI:FIELD_LO];                  // R11
                end
              end
              SEL_CONFIG_STORED:
              begin
                next_config_stored = i_cmd.data;
                next_config_stored[VSEL_BIT] = config_stored[VSEL_BIT]
                                             | i_cmd.data[VSEL_BIT];
                next_config_live = next_config_stored;
              end
              SEL_CONFIG_LIVE:
              begin
                // Select bit has no live twin worth changing
                next_config_live = i_cmd.data;
                next_config_live[VSEL_BIT] = config_live[VSEL_BIT];
              end
              default:
              begin
                // Other registers live elsewhere; accepted here   R04
                next_rsp.done = 1'b1;
              end
            endcase
          end
          CMD_READ_ANY:
          begin
            next_rsp.done = 1'b1;
            case (i_cmd.sel)
              SEL_STATUS_STORED: next_rsp.rdata = status_stored;
              SEL_STATUS_LIVE:   next_rsp.rdata = status_live;
              SEL_CONFIG_STORED: next_rsp.rdata = config_stored;
              SEL_CONFIG_LIVE:   next_rsp.rdata = config_live;
              default:           next_rsp.rdata = 8'h00;
            endcase
          end
          CMD_PROGRAM,
          CMD_ERASE:
          begin
            // Range decode is outside; we only gate on its verdict
            next_rsp.refused = (active_field != FIELD_CLEAR)
                             & i_cmd.in_range;                      // R12
            next_rsp.done    = ~next_rsp.refused;
          end
          CMD_WHOLE_ERASE:
          begin
            next_rsp.refused = (active_field != FIELD_CLEAR);       // R13
            next_rsp.done    = ~next_rsp.refused;
          end
          default:
          begin
            next_rsp.refused = 1'b1;
          end
        endcase
      end
    end

    // Volatile select pins the stored field; user values are lost
    if (next_config_stored[VSEL_BIT])
    begin
      next_status_stored[FIELD_HI:FIELD_LO] = FIELD_LOCKED;         // R14
    end
    // Read-only defaults never move
    next_status_stored[PERR_BIT] = status_stored[PERR_BIT];         // R06
    next_status_stored[EERR_BIT] = status_stored[EERR_BIT];         // R07
    next_status_stored[WEL_BIT]  = status_stored[WEL_BIT];          // R08
    next_status_stored[BUSY_BIT] = status_stored[BUSY_BIT];         // R09
    // Lock mirror tracks the stored bit for zero-latency reads
    next_status_live[LOCK_BIT] = next_status_stored[LOCK_BIT];      // R05

    // Ask the cell array to program whatever stored byte changed
    next_nv.status_we = (next_status_stored != status_stored);
    next_nv.status    = next_status_stored;
    next_nv.config_we = (next_config_stored != config_stored);
    next_nv.config_b  = next_config_stored;
  end

  // Register stage; reset reloads live copies from the stored image
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      status_stored <= i_nv_status_image;
      status_live   <= i_nv_status_image;                   // R15 R06-R09
      config_stored <= i_nv_config_image;
      config_live   <= i_nv_config_image;                           // R15
      o_rsp         <= '0;
      o_nv          <= '0;
    end
    else
    begin
      status_stored <= next_status_stored;
      status_live   <= next_status_live;
      config_stored <= next_config_stored;
      config_live   <= next_config_live;
      o_rsp         <= next_rsp;
      o_nv          <= next_nv;
    end
  end

  // Observation outputs from flops; protection field through the select mux
  assign o_status_live    = status_live;
  assign o_status_stored  = status_stored;
  assign o_config_live    = config_live;
  assign o_protect_active = active_field;

  // Checks on the bank's own behaviour
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  logic guarded_wr;   // Write aimed at status or config one
  assign guarded_wr = i_cmd.valid & hits_guarded;

  sequence s_vol_wr;
    i_cmd.valid && i_cmd.kind == CMD_WRITE_REGISTERS && !locked;
  endsequence

  sequence s_answer_done;
    o_rsp.valid && o_rsp.done && !o_rsp.refused;
  endsequence

  a_lock_refuses: assert property ( // R01
    guarded_wr && locked |=> o_rsp.refused && $stable(status_stored))
    else $error("locked write was not refused");
  a_pin_high_ok: assert property ( // R02
    guarded_wr && wp_high |=> s_answer_done)
    else $error("write refused with pin high");
  a_unlock_ok: assert property ( // R03
    guarded_wr && !status_stored[LOCK_BIT] |=> s_answer_done)
    else $error("write refused with lock clear");
  a_other_free: assert property ( // R04
    i_cmd.valid && i_cmd.kind == CMD_WRITE_ANY && i_cmd.sel == SEL_OTHER
    |=> !o_rsp.refused)
    else $error("other register write refused");
  a_lock_mirror: assert property ( // R05
    status_live[LOCK_BIT] == status_stored[LOCK_BIT])
    else $error("lock mirror differs from stored bit");
  // A write that also sets the select pins the stored field instead (R14)
  a_nv_copy: assert property ( // R10
    s_vol_wr ##0 !vsel ##0 !(i_cmd.cfg_valid && i_cmd.cfg_data[VSEL_BIT])
    |=> status_stored[FIELD_HI:FIELD_LO]
      == $past(i_cmd.data[FIELD_HI:FIELD_LO])
      && status_live[FIELD_HI:FIELD_LO]
      == status_stored[FIELD_HI:FIELD_LO])
    else $error("stored field not written and copied");
  a_vol_keep: assert property ( // R11
    s_vol_wr ##0 vsel |=> $stable(status_stored[FIELD_HI:FIELD_LO])
      && status_live[FIELD_HI:FIELD_LO]
      == $past(i_cmd.data[FIELD_HI:FIELD_LO]))
    else $error("volatile write disturbed stored field");
  a_region_guard: assert property ( // R12
    i_cmd.valid && i_cmd.kind == CMD_PROGRAM && i_cmd.in_range
    && active_field != FIELD_CLEAR |=> o_rsp.refused && !o_rsp.done)
    else $error("program in protected region not refused");
  a_whole_erase: assert property ( // R13
    i_cmd.valid && i_cmd.kind == CMD_WHOLE_ERASE
    |=> o_rsp.refused == ($past(active_field) != FIELD_CLEAR))
    else $error("whole erase gating wrong");
  a_field_pinned: assert property ( // R14
    $rose(config_stored[VSEL_BIT]) |-> status_stored[FIELD_HI:FIELD_LO]
      == FIELD_LOCKED [*2])
    else $error("stored field not held at 111b");
  a_reset_load: assert property ( // R15
    disable iff (1'b0)
    !i_resetn ##1 i_resetn |-> status_live[PERR_BIT]
      == status_stored[PERR_BIT] && status_live[BUSY_BIT]
      == status_stored[BUSY_BIT] && config_live == config_stored)
    else $error("reset did not load live copies");

endmodule : sro_status_bank

//--- sro_pkg.sv
// Shared types and constants for the stored status register one bank
package sro_pkg;

  // Bit positions inside status register one
  localparam int unsigned LOCK_BIT   = 7;   // Write lock, stored and mirror
  localparam int unsigned PERR_BIT   = 6;   // Program error
  localparam int unsigned EERR_BIT   = 5;   // Erase error
  localparam int unsigned FIELD_HI   = 4;   // Protection field top bit
  localparam int unsigned FIELD_LO   = 2;   // Protection field low bit
  localparam int unsigned WEL_BIT    = 1;   // Write enable latch
  localparam int unsigned BUSY_BIT   = 0;   // Busy flag
  // Position of the protection volatility select in config one
  localparam int unsigned VSEL_BIT   = 3;

  // Values after reset and fixed field codes
  localparam logic [7:0] STATUS_FACTORY = 8'h00; // Shipped stored status
  localparam logic [7:0] CONFIG_FACTORY = 8'h00; // Shipped stored config
  localparam logic [2:0] FIELD_FACTORY  = 3'h0;  // Shipped protection
  localparam logic [2:0] FIELD_LOCKED   = 3'h7;  // Field once volatile
  localparam logic [2:0] FIELD_CLEAR    = 3'h0;  // No protection at all
  localparam logic       PIN_IDLE       = 1'h1;  // Sync stage reset level

  // Pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // Commands reaching this bank from the serial command decoder
  typedef enum logic [2:0] {
    CMD_WRITE_REGISTERS,
    CMD_WRITE_ANY,
    CMD_READ_ANY,
    CMD_PROGRAM,
    CMD_ERASE,
    CMD_WHOLE_ERASE
  } sro_cmd_kind_t;

  // Register selected by an any-register command
  typedef enum logic [2:0] {
    SEL_STATUS_STORED,
    SEL_STATUS_LIVE,
    SEL_CONFIG_STORED,
    SEL_CONFIG_LIVE,
    SEL_OTHER
  } sro_reg_sel_t;

  // One command, valid for a single cycle
  typedef struct packed {
    logic          valid;     // Command strobe
    sro_cmd_kind_t kind;      // Which command
    sro_reg_sel_t  sel;       // Target of any-register commands
    logic [7:0]    data;      // Status byte or any-register byte
    logic          cfg_valid; // Write registers carries a config byte
    logic [7:0]    cfg_data;  // Config one byte
    logic          in_range;  // Address lies in the protected region
  } sro_cmd_t;

  // Answer, one cycle after the command
  typedef struct packed {
    logic       valid;   // Answer strobe
    logic       done;    // Command carried out
    logic       refused; // Command ignored
    logic [7:0] rdata;   // Read any register data
  } sro_rsp_t;

  // Status events from the embedded operation engine
  typedef struct packed {
    logic perr_set;  // Program failed
    logic eerr_set;  // Erase failed
    logic err_clr;   // Clear status command
    logic wel_set;   // Write enable command
    logic wel_clr;   // Write disable or operation end
    logic busy;      // Embedded operation running
  } sro_evt_t;

  // Request to program the non-volatile cells
  typedef struct packed {
    logic       status_we; // Program stored status
    logic [7:0] status;    // New stored status byte
    logic       config_we; // Program stored config one
    logic [7:0] config_b;  // New stored config byte
  } sro_nv_t;

endpackage : sro_pkg

//--- sro_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module sro_pin_sync
  import sro_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level
);

  logic [SYNC_STAGES-1:0] stage;      // Shift chain, bit 0 first
  logic [SYNC_STAGES-1:0] next_stage; // Next chain value
  logic                   next_level; // Next filtered level

  // Shift in; first stage only feeds the second
  always_comb
  begin
    next_stage = {stage[SYNC_STAGES-2:0], i_pin};
    // Accept a change only when the last two stages agree
    next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
  end

  // Register chain and filtered level
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      stage   <= {SYNC_STAGES{PIN_IDLE}};
      o_level <= PIN_IDLE;
    end
    else
    begin
      stage   <= next_stage;
      o_level <= next_level;
    end
  end

endmodule : sro_pin_sync

//--- sro_host_model.sv
// Host command driver and stored cell array model for the status bank
`timescale 1ns/1ps
module sro_host_model
  import sro_pkg::*;
#(
  parameter logic [7:0] INIT_STATUS = 8'hE3, // Cells as shipped in this run
  parameter logic [7:0] INIT_CONFIG = 8'h00  // Config cells as shipped
)
(
  input  wire logic     i_sys_clk,
  input  wire sro_rsp_t i_rsp,
  input  wire sro_nv_t  i_nv,
  output sro_cmd_t      o_cmd,
  output logic [7:0]    o_status_image,
  output logic [7:0]    o_config_image
);
  // Idle command and shipped cells at time zero
  initial
  begin
    o_cmd          = '0;
    o_status_image = INIT_STATUS;
    o_config_image = INIT_CONFIG;
  end

  // Cells keep what the bank programs, so a later reset reloads it
  always @(posedge i_sys_clk)
  begin
    if (i_nv.status_we)
      o_status_image <= i_nv.status;
    if (i_nv.config_we)
      o_config_image <= i_nv.config_b;
  end

  // One-cycle strobe, then a bounded wait; no answer leaves r.valid low
  task automatic issue(input sro_cmd_t c, output sro_rsp_t r);
    int n;
    r = '0;
    @(posedge i_sys_clk);
    o_cmd <= c;
    @(posedge i_sys_clk);
    o_cmd.valid <= 1'b0;
    for (n = 0; n < 4; n++)
    begin
      #1;
      if (i_rsp.valid === 1'b1)
      begin
        r = i_rsp;
        break;
      end
      @(posedge i_sys_clk);
    end
  endtask : issue
endmodule : sro_host_model

//--- sro_status_bank_tb.sv
// Self-checking bench for the stored status register one bank
`timescale 1ns/1ps
module sro_status_bank_tb
  import sro_pkg::*;
;
  logic       clk;        // 40 MHz system clock
  logic       resetn;     // Synchronous reset, active low
  logic       wp_n;       // Write-protect pin, low protects
  sro_evt_t   evt;        // Engine events; one pulse near the end of the bench
  sro_cmd_t   cmd;        // Command from the host model
  sro_rsp_t   rsp;        // Answer to the host model
  sro_rsp_t   last;       // Answer of the latest command
  sro_nv_t    nv;         // Cell programming requests
  logic [7:0] st_img;     // Stored status cells
  logic [7:0] cf_img;     // Stored config cells
  logic [7:0] st_live;    // Volatile status one
  logic [7:0] st_stored;  // Stored status one
  logic [7:0] cf_live;    // Volatile config one
  logic [2:0] prot;       // Protection field in force
  int         err_total;  // Mismatches seen
  int         n_compared; // Comparisons made

  sro_status_bank uut (
    .i_sys_clk         (clk),
    .i_resetn          (resetn),
    .i_write_protect_n (wp_n),
    .i_nv_status_image (st_img),
    .i_nv_config_image (cf_img),
    .i_cmd             (cmd),
    .i_evt             (evt),
    .o_rsp             (rsp),
    .o_nv              (nv),
    .o_status_live     (st_live),
    .o_status_stored   (st_stored),
    .o_config_live     (cf_live),
    .o_protect_active  (prot)
  );

  sro_host_model host (
    .i_sys_clk      (clk),
    .i_rsp          (rsp),
    .i_nv           (nv),
    .o_cmd          (cmd),
    .o_status_image (st_img),
    .o_config_image (cf_img)
  );

  // Free-running clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Issue one command; a zero config byte means none is carried
  task automatic run(input sro_cmd_kind_t k, input sro_reg_sel_t s,
                     input logic [7:0] d, input logic [7:0] cd,
                     input logic rng, input logic refd);
    sro_cmd_t c;
    c = '{valid: 1'b1, kind: k, sel: s, data: d,
          cfg_valid: (cd != 8'h00), cfg_data: cd, in_range: rng};
    host.issue(c, last);
    if (last.valid !== 1'b1)
    begin
      err_total++;
      $display("mismatch answer expected 1 seen 0");
      give_verdict();
    end
    chk("refused", {7'h00, last.refused}, {7'h00, refd});
    chk("done", {7'h00, last.done}, {7'h00, ~refd});
  endtask : run

  // Pin change, then time for the synchroniser to settle
  task automatic set_pin(input logic v);
    @(posedge clk);
    wp_n <= v;
    repeat (5) @(posedge clk);
  endtask : set_pin

  // Reset held four cycles per call; defaults checked while in reset
  task automatic do_reset(input logic [7:0] exp_st,
                          input logic [7:0] exp_cf);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("live status", st_live, exp_st);
    chk("live config", cf_live, exp_cf);
    @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Main sequence
  initial
  begin
    resetn     = 1'b0;
    wp_n       = 1'b1;
    evt        = '0;
    err_total  = 0;
    n_compared = 0;
    do_reset(8'hE3, 8'h00);
    // Lock set, pin high: field written and copied live
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h94, 8'h00, 1'b0, 1'b0);
    chk("stored", st_stored, 8'hF7);
    chk("live", st_live, 8'hF6);
    chk("protect", {5'h00, prot}, 8'h05);
    chk("cell write", {7'h00, nv.status_we}, 8'h01);
    // Lock set, pin low: both register groups frozen
    set_pin(1'b0);
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h80, 8'h00, 1'b0, 1'b1);
    run(CMD_WRITE_ANY, SEL_CONFIG_LIVE, 8'h08, 8'h00, 1'b0, 1'b1);
    run(CMD_WRITE_ANY, SEL_STATUS_STORED, 8'h00, 8'h00, 1'b0, 1'b1);
    run(CMD_WRITE_ANY, SEL_OTHER, 8'h55, 8'h00, 1'b0, 1'b0);
    chk("stored", st_stored, 8'hF7);
    chk("config", cf_live, 8'h00);
    // Field 5 in force: region and whole erase refused
    run(CMD_PROGRAM, SEL_OTHER, 8'h00, 8'h00, 1'b1, 1'b1);
    run(CMD_ERASE, SEL_OTHER, 8'h00, 8'h00, 1'b1, 1'b1);
    run(CMD_PROGRAM, SEL_OTHER, 8'h00, 8'h00, 1'b0, 1'b0);
    run(CMD_WHOLE_ERASE, SEL_OTHER, 8'h00, 8'h00, 1'b0, 1'b1);
    // Pin high again: lock cleared, field 2
    set_pin(1'b1);
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h08, 8'h00, 1'b0, 1'b0);
    chk("stored", st_stored, 8'h6B);
    // Lock clear: pin low has no say
    set_pin(1'b0);
    run(CMD_WHOLE_ERASE, SEL_OTHER, 8'h00, 8'h00, 1'b0, 1'b1);
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("protect", {5'h00, prot}, 8'h00);
    run(CMD_WHOLE_ERASE, SEL_OTHER, 8'h00, 8'h00, 1'b0, 1'b0);
    run(CMD_READ_ANY, SEL_STATUS_LIVE, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("read live", last.rdata, 8'h62);
    // Volatile select: stored field pinned, live field takes writes
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h00, 8'h08, 1'b0, 1'b0);
    chk("stored", st_stored, 8'h7F);
    chk("config write", {7'h00, nv.config_we}, 8'h01);
    run(CMD_WRITE_REGISTERS, SEL_OTHER, 8'h0C, 8'h00, 1'b0, 1'b0);
    chk("stored", st_stored, 8'h7F);
    chk("live", st_live, 8'h6E);
    chk("protect", {5'h00, prot}, 8'h03);
    run(CMD_WRITE_ANY, SEL_STATUS_STORED, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("stored", st_stored, 8'h7F);
    // Engine events: error set beats clear, busy follows its level
    @(posedge clk);
    evt <= '{perr_set: 1'b1, err_clr: 1'b1, busy: 1'b1, default: 1'b0};
    @(posedge clk);
    evt <= '0;
    #1;
    chk("events", st_live, 8'h4F);
    // Second reset reloads live copies from the cells
    do_reset(8'h7F, 8'h08);
    give_verdict();
  end
endmodule : sro_status_bank_tb
